// ==== aic_top.sv ====
//Operation
// - Tolerance band 0..25 %, reset 2 %.
// - Sign change widens zero crossing by band.
// - Minimum value turns band into hysteresis.
// - Hold minimum until crossing opposite band edge.
// - Modes off/warn/stop/fault, threshold 10 %.
// - Mode 2 warns and ramps down.
// - Mode 2 faults after hold time.
// - Mode 3 warns, faults and coasts.
// - Monitoring ignores inverter enable.
// - Fifteen filter constants, 0 to 5000 ms.
// - Zero constant passes input unfiltered.
// - Nonzero constant low-pass averages input.
// - Voltage output needs switch and mode 5.
// - Output follows two point straight line.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module aic_top #(
  parameter int unsigned TICK_CYCLES = aic_pkg::TICK_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        CE,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [15:0] MULTIFUNCTION_ANALOG_IN,
  input  wire logic        DIRECTION_SELECT_SWITCH,
  input  wire logic        START,
  output logic      [15:0] REF_OUT,
  output logic             WARN,
  output logic             STOP_RAMP,
  output logic             COAST,
  output logic             FAULT,
  output logic             VOLTAGE_OUT_EN,
  output logic      [15:0] VOLTAGE_OUT_SIGNAL,
  output logic             IRQ
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WARN  = 4'h2,
    ST_STOP  = 4'h4,
    ST_FAULT = 4'h8
  } aic_mon_e;

  aic_flt_if flt ();

  logic [10:0]        ctrl_q;
  logic signed [15:0] tol_q, x1_q, y1_q, x2_q, y2_q, min_q;
  logic [15:0]        hold_q, vout_q;
  logic [2:0]         st_q, st_d, mask_q;
  logic [31:0]        rdata_q, rdata_d;
  logic [16:0]        tick_cnt_q;
  logic               tick_q;
  logic signed [15:0] ain_q;
  aic_mon_e           state_q, state_d;
  logic               coast_q, start_hi_q;
  logic [15:0]        hold_cnt_q;
  logic               dir_pos_q;
  logic signed [15:0] ref_q, ref_d;
  logic               warn_q, stop_q, coast_out_q, fault_q, vout_en_q, irq_q;
  logic [15:0]        vout_sig_q;

  // Control fields
  wire logic [1:0] mon_mode  = ctrl_q[aic_pkg::CTRL_MON_LSB +: 2];
  wire logic [3:0] flt_idx   = ctrl_q[aic_pkg::CTRL_FLT_LSB +: 4];
  wire logic [3:0] term_mode = ctrl_q[aic_pkg::CTRL_TERM_LSB +: 4];

  // Register decode
  wire logic wr_ctrl = WR && ADDR == aic_pkg::OFS_CTRL;
  wire logic wr_tol  = WR && ADDR == aic_pkg::OFS_TOL;
  wire logic wr_x1   = WR && ADDR == aic_pkg::OFS_X1;
  wire logic wr_y1   = WR && ADDR == aic_pkg::OFS_Y1;
  wire logic wr_x2   = WR && ADDR == aic_pkg::OFS_X2;
  wire logic wr_y2   = WR && ADDR == aic_pkg::OFS_Y2;
  wire logic wr_min  = WR && ADDR == aic_pkg::OFS_MINVAL;
  wire logic wr_hold = WR && ADDR == aic_pkg::OFS_HOLD;
  wire logic wr_vout = WR && ADDR == aic_pkg::OFS_VOUT;
  wire logic wr_mask = WR && ADDR == aic_pkg::OFS_MASK;
  wire logic rd_st   = RD && ADDR == aic_pkg::OFS_STATUS;

  // band clamped to its upper limit, negatives to zero
  wire logic signed [15:0] wtol = $signed(WDATA[15:0]);
  wire logic signed [15:0] tol_w = wtol > aic_pkg::TOL_MAX ? aic_pkg::TOL_MAX :
                                   (wtol < 16'sh0 ? 16'sh0 : wtol);
  // index beyond the last time constant takes the longest one
  wire logic [3:0] flt_w = WDATA[aic_pkg::CTRL_FLT_LSB +: 4] > aic_pkg::FLT_LAST ?
                           aic_pkg::FLT_LAST : WDATA[aic_pkg::CTRL_FLT_LSB +: 4];

  // Configuration registers
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= 11'h000;
      tol_q  <= aic_pkg::TOL_RST;
      x1_q   <= aic_pkg::X1_RST;
      y1_q   <= aic_pkg::Y1_RST;
      x2_q   <= aic_pkg::X2_RST;
      y2_q   <= aic_pkg::Y2_RST;
      min_q  <= aic_pkg::MINVAL_RST;
      hold_q <= aic_pkg::HOLD_RST;
      vout_q <= 16'h0000;
      mask_q <= 3'h0;
    end else if (CE) begin
      if (wr_ctrl) ctrl_q <= {1'b0, WDATA[9:6], flt_w, WDATA[1:0]};
      if (wr_tol)  tol_q  <= tol_w;
      if (wr_x1)   x1_q   <= $signed(WDATA[15:0]);
      if (wr_y1)   y1_q   <= $signed(WDATA[15:0]);
      if (wr_x2)   x2_q   <= $signed(WDATA[15:0]);
      if (wr_y2)   y2_q   <= $signed(WDATA[15:0]);
      if (wr_min)  min_q  <= $signed({1'b0, WDATA[14:0]});
      if (wr_hold) hold_q <= WDATA[15:0];
      if (wr_vout) vout_q <= WDATA[15:0];
      if (wr_mask) mask_q <= WDATA[2:0];
    end
  end

  // Read mux, unmapped addresses answer zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ADDR)
      aic_pkg::OFS_CTRL:   rdata_d = {21'h0, ctrl_q};
      aic_pkg::OFS_TOL:    rdata_d = {16'h0, tol_q};
      aic_pkg::OFS_X1:     rdata_d = {{16{x1_q[15]}}, x1_q};
      aic_pkg::OFS_Y1:     rdata_d = {{16{y1_q[15]}}, y1_q};
      aic_pkg::OFS_X2:     rdata_d = {{16{x2_q[15]}}, x2_q};
      aic_pkg::OFS_Y2:     rdata_d = {{16{y2_q[15]}}, y2_q};
      aic_pkg::OFS_MINVAL: rdata_d = {16'h0, min_q};
      aic_pkg::OFS_HOLD:   rdata_d = {16'h0, hold_q};
      aic_pkg::OFS_VOUT:   rdata_d = {16'h0, vout_q};
      aic_pkg::OFS_STATUS: rdata_d = {29'h0, st_q};
      aic_pkg::OFS_MASK:   rdata_d = {29'h0, mask_q};
      aic_pkg::OFS_STATE:  rdata_d = {23'h0, dir_pos_q, coast_q, state_q, fault_q, stop_q, warn_q};
      aic_pkg::OFS_REF:    rdata_d = {{16{ref_q[15]}}, ref_q};
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) rdata_q <= 32'h0000_0000;
    else if (CE) rdata_q <= RD ? rdata_d : 32'h0000_0000;
  end

  // Millisecond tick and input sample register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tick_cnt_q <= 17'h00000;
      tick_q     <= 1'b0;
      ain_q      <= 16'sh0;
    end else if (CE) begin
      tick_q     <= tick_cnt_q == 17'(TICK_CYCLES - 1);
      tick_cnt_q <= tick_cnt_q == 17'(TICK_CYCLES - 1) ? 17'h00000 : tick_cnt_q + 17'h00001;
      ain_q      <= $signed(MULTIFUNCTION_ANALOG_IN);
    end
  end

  // Averaging filter on the sampled input
  assign flt.sample = ain_q;
  assign flt.tick   = tick_q;
  assign flt.tc_idx = flt_idx;
  aic_filter u_filter (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .ce    (CE),
    .f     (flt.flt)
  );

  wire logic signed [15:0] xf = flt.result;
  wire logic signed [15:0] y_lin;
  wire logic signed [15:0] xz;
  wire logic               bipolar;
  aic_charmap u_charmap (
    .x       (xf),
    .x1      (x1_q),
    .y1      (y1_q),
    .x2      (x2_q),
    .y2      (y2_q),
    .y       (y_lin),
    .xz      (xz),
    .bipolar (bipolar)
  );

  // Band edges around the zero crossing of the line
  wire logic signed [16:0] band_hi = 17'(xz) + 17'(tol_q);
  wire logic signed [16:0] band_lo = 17'(xz) - 17'(tol_q);
  wire logic go_neg = 17'(xf) < band_lo;
  wire logic go_pos = 17'(xf) > band_hi;
  wire logic in_band = !go_neg && !go_pos;
  wire logic signed [15:0] y_abs = y_lin[15] ? -y_lin : y_lin;
  wire logic signed [15:0] y_mag = y_abs < min_q ? min_q : y_abs;

  // inside the band the output holds the remembered minimum
  // holding at the minimum instead of zero gives hysteresis
  always_comb begin
    ref_d = y_lin[15] ? -y_mag : y_mag;
    if (bipolar) begin
      if (in_band || y_lin[15] == dir_pos_q || y_lin == 16'sh0) ref_d = dir_pos_q ? min_q : -min_q;
    end else if (y_lin == 16'sh0) begin
      ref_d = 16'sh0;
    end
  end

  // direction flips only past the far band edge
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dir_pos_q <= 1'b1;
      ref_q     <= 16'sh0;
    end else if (CE) begin
      if (go_neg) dir_pos_q <= 1'b0;
      else if (go_pos) dir_pos_q <= 1'b1;
      ref_q <= ref_d;
    end
  end

  // monitoring does not look at any enable of the inverter
  // an output-configured terminal has nothing to monitor
  wire logic term_out  = DIRECTION_SELECT_SWITCH && term_mode == aic_pkg::TERM_VOUT;
  wire logic mon_on    = mon_mode != aic_pkg::MON_OFF && !term_out;
  // raw sample below 1 V or 2 mA
  wire logic under     = mon_on && ain_q < aic_pkg::UNDER_THR;
  wire logic hold_done = hold_cnt_q >= hold_q;
  wire logic restart   = !under && start_hi_q && !START;

  // Undershoot supervisor
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE, ST_WARN: begin
        if (under && mon_mode == aic_pkg::MON_TRIP) state_d = ST_FAULT;
        else if (under && mon_mode == aic_pkg::MON_STOP) state_d = ST_STOP;
        else if (under) state_d = ST_WARN;
        else state_d = ST_IDLE;
      end
      // fault once the hold time has run out
      ST_STOP:  if (tick_q && hold_done) state_d = ST_FAULT;
      // leave only after cause cleared and start toggled
      ST_FAULT: if (restart) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  wire logic to_trip = state_d == ST_FAULT && state_q != ST_FAULT;
  wire logic coast_d = state_d != ST_FAULT ? 1'b0 :
                       (to_trip ? state_q != ST_STOP : coast_q);

  // Supervisor state, hold timer and start toggle tracker
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_q    <= ST_IDLE;
      coast_q    <= 1'b0;
      hold_cnt_q <= 16'h0000;
      start_hi_q <= 1'b0;
    end else if (CE) begin
      state_q    <= state_d;
      coast_q    <= coast_d;
      hold_cnt_q <= state_q != ST_STOP ? 16'h0000 :
                    (tick_q && !hold_done ? hold_cnt_q + 16'h0001 : hold_cnt_q);
      start_hi_q <= state_q == ST_FAULT && (start_hi_q || (START && !under));
    end
  end

  // mode 2 forces ramp-down regardless of the stop setting
  // mode 3 warns, faults and lets the drive coast
  wire logic warn_d  = state_d != ST_IDLE;
  wire logic stop_d  = state_d == ST_STOP || (state_d == ST_FAULT && !coast_d);
  wire logic fault_d = state_d == ST_FAULT;

  // Sticky events: a new event wins over the read that clears
  assign st_d = (st_q & (rd_st ? 3'h0 : 3'h7)) |
                {fault_d && !fault_q, stop_d && !stop_q, warn_d && !warn_q};

  // Outputs and interrupt status, all from flops
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      warn_q      <= 1'b0;
      stop_q      <= 1'b0;
      coast_out_q <= 1'b0;
      fault_q     <= 1'b0;
      st_q        <= 3'h0;
      irq_q       <= 1'b0;
      vout_en_q   <= 1'b0;
      vout_sig_q  <= 16'h0000;
    end else if (CE) begin
      warn_q      <= warn_d;
      stop_q      <= stop_d;
      coast_out_q <= coast_d;
      fault_q     <= fault_d;
      st_q        <= st_d;
      irq_q       <= |(st_d & mask_q);
      // output only with switch on output and mode 5
      vout_en_q   <= term_out;
      vout_sig_q  <= term_out ? vout_q : 16'h0000;
    end
  end

  assign RDATA              = rdata_q;
  assign REF_OUT            = ref_q;
  assign WARN               = warn_q;
  assign STOP_RAMP          = stop_q;
  assign COAST              = coast_out_q;
  assign FAULT              = fault_q;
  assign IRQ                = irq_q;
  assign VOLTAGE_OUT_EN     = vout_en_q;
  assign VOLTAGE_OUT_SIGNAL = vout_sig_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  property p_tol_range;
    tol_q >= 16'sh0 && tol_q <= aic_pkg::TOL_MAX;
  endproperty
  a_tol_range: assert property (p_tol_range) else $error("Tolerance out of range");
  property p_mode1;
    CE && state_q == ST_IDLE && under && mon_mode == aic_pkg::MON_WARN
      |=> WARN && !STOP_RAMP && !FAULT;
  endproperty
  a_mode1: assert property (p_mode1) else $error("Mode 1 did not warn only");
  property p_mode2;
    CE && state_q == ST_IDLE && under && mon_mode == aic_pkg::MON_STOP
      |=> WARN && STOP_RAMP && !COAST && !FAULT;
  endproperty
  a_mode2: assert property (p_mode2) else $error("Mode 2 did not ramp down");
  property p_hold_fault;
    CE && state_q == ST_STOP && tick_q && hold_done |=> FAULT && STOP_RAMP;
  endproperty
  a_hold_fault: assert property (p_hold_fault) else $error("No fault after hold time");
  property p_no_early_fault;
    state_q == ST_STOP && !hold_done |=> !FAULT;
  endproperty
  a_no_early_fault: assert property (p_no_early_fault) else $error("Fault before hold time");
  property p_mode3;
    CE && state_q == ST_IDLE && under && mon_mode == aic_pkg::MON_TRIP
      |=> WARN && FAULT && COAST && !STOP_RAMP;
  endproperty
  a_mode3: assert property (p_mode3) else $error("Mode 3 did not trip and coast");
  property p_dir_hold;
    CE && dir_pos_q && !go_neg |=> dir_pos_q;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("Direction flipped inside band");
  property p_vout;
    CE |=> VOLTAGE_OUT_EN == $past(DIRECTION_SELECT_SWITCH && term_mode == aic_pkg::TERM_VOUT);
  endproperty
  a_vout: assert property (p_vout) else $error("Voltage output gating wrong");
  property p_band_sign;
    CE && bipolar && !go_neg && !go_pos && dir_pos_q |=> !REF_OUT[15];
  endproperty
  a_band_sign: assert property (p_band_sign) else $error("Sign changed inside band");
  property p_rdata_once;
    CE && !RD |=> RDATA == 32'h0000_0000;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("Read data outside its cycle");
  c_mode2_fault: cover property (state_q == ST_STOP ##1 state_q == ST_FAULT);
  c_mode3_trip: cover property (COAST && FAULT);
  c_dir_change: cover property (dir_pos_q ##1 !dir_pos_q);
  c_restart: cover property (state_q == ST_FAULT ##1 state_q == ST_IDLE);
  c_irq: cover property (IRQ);
endmodule : aic_top
`default_nettype wire

// ==== aic_pkg.sv ====
package aic_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TOL    = 8'h04;
  localparam logic [7:0] OFS_X1     = 8'h08;
  localparam logic [7:0] OFS_Y1     = 8'h0c;
  localparam logic [7:0] OFS_X2     = 8'h10;
  localparam logic [7:0] OFS_Y2     = 8'h14;
  localparam logic [7:0] OFS_MINVAL = 8'h18;
  localparam logic [7:0] OFS_HOLD   = 8'h1c;
  localparam logic [7:0] OFS_VOUT   = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MASK   = 8'h28;
  localparam logic [7:0] OFS_STATE  = 8'h2c;
  localparam logic [7:0] OFS_REF    = 8'h30;
  // Control register field positions
  localparam int CTRL_MON_LSB  = 0;
  localparam int CTRL_FLT_LSB  = 2;
  localparam int CTRL_TERM_LSB = 6;
  // Values in 0.01 % of full scale (10000 = 10 V or 20 mA)
  localparam logic signed [15:0] TOL_MAX    = 16'sh09c4; // 25.00 %
  localparam logic signed [15:0] TOL_RST    = 16'sh00c8; // 2.00 %
  localparam logic signed [15:0] X1_RST     = -16'sh2648; // -98.00 %
  localparam logic signed [15:0] Y1_RST     = -16'sh2710; // -100.00 %
  localparam logic signed [15:0] X2_RST     = 16'sh2648;
  localparam logic signed [15:0] Y2_RST     = 16'sh2710;
  localparam logic signed [15:0] MINVAL_RST = 16'sh0000;
  localparam logic [15:0]        HOLD_RST   = 16'h03e8;  // Hold time in ms
  // 1 V of 10 V and 2 mA of 20 mA are both 10.00 %
  localparam logic signed [15:0] UNDER_THR  = 16'sh03e8;
  // Monitoring modes
  localparam logic [1:0] MON_OFF  = 2'h0;
  localparam logic [1:0] MON_WARN = 2'h1;
  localparam logic [1:0] MON_STOP = 2'h2;
  localparam logic [1:0] MON_TRIP = 2'h3;
  localparam logic [3:0] TERM_VOUT = 4'h5;
  localparam logic [3:0] FLT_LAST  = 4'he;   // 15 time constants, index 0..14
  // Filter sample tick
  localparam int unsigned CLK_HZ   = 125000000;
  localparam int unsigned TICK_US  = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
endpackage : aic_pkg

// ==== aic_flt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface aic_flt_if;
  logic signed [15:0] sample;
  logic               tick;
  logic [3:0]         tc_idx;
  logic signed [15:0] result;
  modport src (output sample, output tick, output tc_idx, input result);
  modport flt (input sample, input tick, input tc_idx, output result);
endinterface : aic_flt_if
`default_nettype wire

// ==== aic_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module aic_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  aic_flt_if.flt    f
);
  logic signed [31:0] acc_q;
  logic signed [15:0] res_q;
  logic signed [32:0] diff;
  logic signed [50:0] prod;
  logic        [16:0] coef;

  // Coefficient is 65536 / time constant in ms at a 1 ms tick
  function automatic logic [16:0] tc_coef(input logic [3:0] idx);
    case (idx)
      4'h1: tc_coef = 17'h08000; 4'h2: tc_coef = 17'h04000;
      4'h3: tc_coef = 17'h02000; 4'h4: tc_coef = 17'h01000;
      4'h5: tc_coef = 17'h00800; 4'h6: tc_coef = 17'h00400;
      4'h7: tc_coef = 17'h00200; 4'h8: tc_coef = 17'h00100;
      4'h9: tc_coef = 17'h00080; 4'ha: tc_coef = 17'h00042;
      4'hb: tc_coef = 17'h00021; 4'hc: tc_coef = 17'h00016;
      4'hd: tc_coef = 17'h00010; 4'he: tc_coef = 17'h0000d;
      default: tc_coef = 17'h10000;
    endcase
  endfunction : tc_coef

  assign coef = tc_coef(f.tc_idx);
  // Sign kept on the scaled sample, else negative inputs would pull upward
  assign diff = 33'($signed({f.sample, 16'h0000})) - 33'(acc_q);
  assign prod = diff * $signed({1'b0, coef});
  assign f.result = res_q;

  // Accumulator moves only on the tick, or every cycle when bypassed, output follows it or bypasses it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 32'sh0;
      res_q <= 16'sh0;
    end else if (ce) begin
      if (f.tc_idx == 4'h0) begin
        acc_q <= {f.sample, 16'h0000};
        res_q <= f.sample;
      end else if (f.tick) begin
        acc_q <= acc_q + 32'(prod >>> 16);
        res_q <= 16'(( acc_q + 32'(prod >>> 16)) >>> 16);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_bypass;
    ce && f.tc_idx == 4'h0 |=> f.result == $past(f.sample);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass did not pass sample");
  property p_hold_between_ticks;
    ce && f.tc_idx != 4'h0 && !f.tick |=> $stable(acc_q);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("Filter moved off tick");
  property p_toward_input;
    ce && f.tc_idx != 4'h0 && f.tick && diff > 33'sh0 && coef != 17'h0 |=> acc_q >= $past(acc_q);
  endproperty
  a_toward_input: assert property (p_toward_input) else $error("Filter moved away from input");
endmodule : aic_filter
`default_nettype wire

// ==== aic_charmap.sv ====
`timescale 1ns/1ps
`default_nettype none
module aic_charmap (
  input  wire logic signed [15:0] x,
  input  wire logic signed [15:0] x1,
  input  wire logic signed [15:0] y1,
  input  wire logic signed [15:0] x2,
  input  wire logic signed [15:0] y2,
  output logic signed      [15:0] y,
  output logic signed      [15:0] xz,
  output logic                    bipolar
);
  logic signed [16:0] dx;
  logic signed [16:0] dy;
  logic signed [34:0] num;
  logic signed [34:0] quo;
  logic signed [34:0] zq;
  logic signed [34:0] ysum;

  function automatic logic signed [15:0] sat16(input logic signed [34:0] v);
    if (v > 35'sh7fff) sat16 = 16'sh7fff;
    else if (v < -35'sh8000) sat16 = -16'sh8000;
    else sat16 = 16'(v);
  endfunction : sat16

  // two point straight line, degenerate span yields Y1
  assign dx   = 17'(x2) - 17'(x1);
  assign dy   = 17'(y2) - 17'(y1);
  assign num  = 35'(dy) * 35'(17'(x) - 17'(x1));
  assign quo  = (dx == 17'sh0) ? 35'sh0 : num / 35'(dx);
  assign ysum = quo + 35'(y1);
  assign y    = sat16(ysum);
  // Input at which the line crosses zero, used to centre the band
  assign zq   = (dy == 17'sh0) ? 35'sh0 : (35'(y1) * 35'(dx)) / 35'(dy);
  assign xz   = sat16(35'(x1) - zq);
  assign bipolar = (y1[15] != y2[15]) && (y1 != 16'sh0) && (y2 != 16'sh0);
endmodule : aic_charmap
`default_nettype wire

// ==== aic_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side analog source: follows the commanded level, runs the restart
module aic_src (
  input  wire logic        clk,
  input  wire logic [15:0] level,
  input  wire logic        restart,
  output logic      [15:0] ain,
  output logic             start
);
  logic [1:0] step_q = 2'h0;
  // clear then toggle
  // The cause is gone before start toggles, else the restart is void
  always_ff @(posedge clk) begin
    if (restart || step_q != 2'h0) begin
      step_q <= step_q + 2'h1;
    end
  end
  assign ain   = (step_q != 2'h0) ? 16'h07d0 : level;
  assign start = (step_q == 2'h2);
endmodule : aic_src
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sw = 1'b0;
  logic        restart = 1'b0;
  logic [15:0] lvl = 16'h07d0;
  logic [31:0] rdata;
  logic [15:0] ain, ref_out, vout;
  logic        start, warn, stop, coast, fault, vout_en, irq;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  // Clock, and a hang guard well above the expected run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  // Block under test and its analog source
  aic_top #(.TICK_CYCLES(10)) u_aic_top (.CLK_SYS(clk), .RESETN(rst_n), .CE(1'b1),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MULTIFUNCTION_ANALOG_IN(ain), .DIRECTION_SELECT_SWITCH(sw), .START(start),
    .REF_OUT(ref_out), .WARN(warn), .STOP_RAMP(stop), .COAST(coast), .FAULT(fault),
    .VOLTAGE_OUT_EN(vout_en), .VOLTAGE_OUT_SIGNAL(vout), .IRQ(irq));
  aic_src u_aic_src (.clk(clk), .level(lvl), .restart(restart), .ain(ain), .start(start));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Strobes drop a cycle apart so no signal is driven twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rd_chk
  task automatic put(input logic [15:0] v, input int n);
    @(posedge clk);
    lvl <= v;
    cyc(n);
  endtask : put
  task automatic vchk(input logic s, input logic [31:0] c, input logic [31:0] e);
    wr_reg(aic_pkg::OFS_CTRL, c);
    @(posedge clk);
    sw <= s;
    cyc(3);
    chk("vout", e, {15'h0, vout_en, vout});
  endtask : vchk
  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence of register and analog scenarios
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(aic_pkg::OFS_TOL, 32'h000000c8);
    rd_chk(aic_pkg::OFS_X1, 32'hffffd9b8);
    rd_chk(aic_pkg::OFS_Y1, 32'hffffd8f0);
    rd_chk(aic_pkg::OFS_HOLD, 32'h000003e8);
    rd_chk(8'h3c, 32'h0);
    wr_reg(aic_pkg::OFS_TOL, 32'h00000bb8);
    rd_chk(aic_pkg::OFS_TOL, 32'h000009c4);
    wr_reg(aic_pkg::OFS_TOL, 32'h000000c8);
    for (int i = 0; i < 16; i++) begin
      wr_reg(aic_pkg::OFS_CTRL, 32'(i) << 2);
      rd_chk(aic_pkg::OFS_CTRL, 32'((i > 14) ? 14 : i) << 2);
    end
    wr_reg(aic_pkg::OFS_CTRL, 32'h0);
    put(16'h1324, 6);
    chk("ref", 32'h1388, 32'($signed(ref_out)));
    put(16'h0064, 6);
    chk("ref", 32'h0, 32'($signed(ref_out)));
    wr_reg(aic_pkg::OFS_MINVAL, 32'h1f4);
    put(16'h1324, 6);
    put(16'hff9c, 6);
    chk("ref", 32'h1f4, 32'($signed(ref_out)));
    put(16'hecdc, 6);
    chk("ref", 32'hffffec78, 32'($signed(ref_out)));
    put(16'h0064, 6);
    chk("ref", 32'hfffffe0c, 32'($signed(ref_out)));
    wr_reg(aic_pkg::OFS_MINVAL, 32'h0);
    wr_reg(aic_pkg::OFS_CTRL, 32'h4);
    put(16'h0000, 300);
    put(16'h1324, 4);
    chk("flt", 32'h1, {31'h0, ref_out !== 16'h1388});
    cyc(500);
    chk("flt", 32'h1, {31'h0, ref_out > 16'h1370 && ref_out < 16'h13a0});
    put(16'hecdc, 500);
    chk("flt", 32'hffffec78, 32'($signed(ref_out)));
    wr_reg(aic_pkg::OFS_VOUT, 32'h1b58);
    vchk(1'b1, 32'h140, 32'h11b58);
    vchk(1'b1, 32'h100, 32'h0);
    vchk(1'b0, 32'h140, 32'h0);
    wr_reg(aic_pkg::OFS_CTRL, 32'h1);
    put(16'h03e7, 4);
    chk("flags", 32'h8, {28'h0, warn, stop, coast, fault});
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(aic_pkg::OFS_MASK, 32'h7);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk(aic_pkg::OFS_STATUS, 32'h1);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    put(16'h03e8, 4);
    chk("flags", 32'h0, {28'h0, warn, stop, coast, fault});
    wr_reg(aic_pkg::OFS_X1, 32'h3e8);
    wr_reg(aic_pkg::OFS_HOLD, 32'h3);
    wr_reg(aic_pkg::OFS_CTRL, 32'h2);
    put(16'h01f4, 4);
    chk("flags", 32'hc, {28'h0, warn, stop, coast, fault});
    for (int k = 0; k < 100 && fault !== 1'b1; k++) cyc(1);
    chk("fault", 32'h3, {30'h0, fault, stop});
    put(16'h07d0, 2);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    cyc(8);
    chk("flags", 32'h0, {28'h0, warn, stop, coast, fault});
    wr_reg(aic_pkg::OFS_CTRL, 32'h3);
    put(16'h01f4, 4);
    chk("flags", 32'hb, {28'h0, warn, stop, coast, fault});
    end_sim();
  end
endmodule : testbench
`default_nettype wire
